// >>> cbs_defines.svh
// Functional notes
// - zero-page indexed store: four cycles, dummy read at base, write at base+index.
// - indirect-indexed store reads pointer, base bytes, then dummy read without carry.
// - indirect-indexed store writes carried address in sixth cycle, page cross or not.
// - zero-page modify: five cycles, read, unmodified write, modified write.
// - absolute modify: six cycles, two address bytes, read, two writes.
// - zero-page X modify: six cycles, dummy base read, address wraps in page zero.
// - absolute X modify: seven cycles, dummy read, real read, two writes.
// - push: three cycles, dummy read at counter+1, write at stack pointer.
// - pull: four cycles, dummy reads, value read at stack pointer plus one.
// - call: target low, dummy stack read, push high, push low, target high.
// - break/interrupt: seven cycles; second cycle reads counter+1 or counter.
// - entry pushes counter high, counter low, status at sp, sp-1, sp-2.
// - vectors FFFE/FFFF break and irq, FFFA/FFFB nmi, FFFC/FFFD reset.
// - return from interrupt: six cycles, pulls status, low, high; no increment.
// - absolute jump: three cycles, target bytes at counter+1 and +2.
// - indirect jump: five cycles, target high read at pointer low plus one.
// - return from subroutine: six cycles, dummy read at restored, resume at plus one.
// - branch: two, three or four cycles; uncarried address first, then carried.
// - when halted by stepping, stop only in a read cycle, never a write.
// - every instruction starts with an opcode read at the counter.
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

`define CBS_ZERO_PAGE     8'h00
`define CBS_STACK_PAGE    8'h01
`define CBS_SP_RESET      8'hFF
`define CBS_VEC_BREAK     16'hFFFE
`define CBS_VEC_NMI       16'hFFFA
`define CBS_VEC_RESET     16'hFFFC
`define CBS_ENTRY_VEC_LO  3'd5

`endif

// >>> cbs_memory_model.sv
`default_nettype none
module cbs_memory_model (
  // clock
  input  wire logic        sys_clk_in,
  // bus from the sequencer
  input  wire logic [15:0] addr_in,
  input  wire logic        rw_in,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535] = '{default: 8'h00};
  logic [7:0] last_r = 8'h00;

  // zero-wait reads; released line shows inverse of last read
  assign data_out = rw_in ? mem[addr_in] : ~last_r;
  always @(posedge sys_clk_in) begin
    if (!rw_in) begin
      mem[addr_in] <= data_in;
    end else begin
      last_r <= mem[addr_in];
    end
  end
endmodule : cbs_memory_model
`default_nettype wire

// >>> cbs_pkg.sv
`default_nettype none
package cbs_pkg;

  // instruction class, decoded outside from the opcode byte
  typedef enum logic [4:0] {
    CBS_OTHER,
    CBS_ZPX_ST,
    CBS_ZPY_ST,
    CBS_INDY_ST,
    CBS_RMW_ZP,
    CBS_RMW_ABS,
    CBS_RMW_ZPX,
    CBS_RMW_ABSX,
    CBS_PUSH,
    CBS_PULL,
    CBS_CALL,
    CBS_BREAK,
    CBS_INT,
    CBS_RESET,
    CBS_RTI,
    CBS_JMP_ABS,
    CBS_JMP_IND,
    CBS_RTS,
    CBS_BRANCH
  } cbs_class_t;

endpackage : cbs_pkg
`default_nettype wire

// >>> cbs_sequencer.sv
`include "cbs_defines.svh"
`default_nettype none
module cbs_sequencer
  import cbs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // stepping control
  input  wire logic       ready_in,
  // decoder and register file
  input  wire cbs_class_t op_class_in,
  input  wire logic [7:0] index_x_in,
  input  wire logic [7:0] index_y_in,
  input  wire logic [7:0] store_data_in,
  input  wire logic [7:0] status_in,
  input  wire logic [7:0] modify_data_in,
  input  wire logic       branch_taken_in,
  input  wire logic       irq_req_in,
  input  wire logic       nmi_req_in,
  // memory bus
  input  wire logic [7:0] data_in,
  output logic [15:0]     addr_out,
  output logic [7:0]      data_out,
  output logic            data_oe_out,
  output logic            rw_out,
  output logic            sync_out,
  output logic [2:0]      cycle_state_index_out,
  // captured operand
  output logic [7:0]      operand_out,
  output logic            operand_valid_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  cbs_class_t  cls_r, cls_nxt;
  logic [2:0]  t_r, t_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic        rw_r, rw_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  sp_r, sp_nxt;
  logic [7:0]  effective_low_byte_r, lo_nxt;
  logic [7:0]  effective_high_byte_r, hi_nxt;
  logic [7:0]  pointer_low_byte_r, ptr_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic [7:0]  opnd_r, opnd_nxt;
  logic        sync_r, opv_r, opv_nxt, oe_r;

  // ****************************************************************
  // helpers
  // ****************************************************************
  logic [15:0] pc1, pc2, pc3, ret_addr, br_tgt, stk, stk_up;
  logic [7:0]  idx;
  logic [8:0]  bal_sum;
  logic        advance;

  assign pc1      = pc_r + 16'h0001;
  assign pc2      = pc_r + 16'h0002;
  assign pc3      = pc_r + 16'h0003;
  assign ret_addr = (cls_r == CBS_INT) ? pc_r : pc2;
  assign br_tgt   = pc2 + {{8{data_in[7]}}, data_in};
  assign stk      = {`CBS_STACK_PAGE, sp_r};
  assign stk_up   = {`CBS_STACK_PAGE, sp_r + 8'h01};
  assign idx      = (cls_r == CBS_ZPY_ST || cls_r == CBS_INDY_ST) ? index_y_in : index_x_in;
  assign bal_sum  = {1'b0, effective_low_byte_r} + {1'b0, idx};
  // halt only while a read is on the bus
  assign advance  = ready_in | ~rw_r;

  // ****************************************************************
  // next bus cycle
  // ****************************************************************
  always_comb begin
    cls_nxt   = cls_r;
    t_nxt     = t_r + 3'd1;
    addr_nxt  = addr_r;
    rw_nxt    = 1'b1;
    wdata_nxt = wdata_r;
    pc_nxt    = pc_r;
    sp_nxt    = sp_r;
    lo_nxt    = effective_low_byte_r;
    hi_nxt    = effective_high_byte_r;
    ptr_nxt   = pointer_low_byte_r;
    vec_nxt   = vec_r;
    opnd_nxt  = opnd_r;
    opv_nxt   = 1'b0;
    if (t_r == 3'd0) begin
      if (nmi_req_in || irq_req_in) begin
        cls_nxt  = CBS_INT;
        addr_nxt = pc_r;
        vec_nxt  = nmi_req_in ? `CBS_VEC_NMI : `CBS_VEC_BREAK;
      end else begin
        cls_nxt  = op_class_in;
        addr_nxt = pc1;
        vec_nxt  = `CBS_VEC_BREAK;
      end
    end else begin
      if (t_r == 3'd1) begin
        lo_nxt = data_in;
      end
      unique case (cls_r)
        CBS_OTHER: begin
          t_nxt    = 3'd0;
          addr_nxt = pc1;
          pc_nxt   = pc1;
        end
        CBS_ZPX_ST, CBS_ZPY_ST: begin
          if (t_r == 3'd1) begin
            addr_nxt = {`CBS_ZERO_PAGE, data_in};
          end else if (t_r == 3'd2) begin
            addr_nxt  = {`CBS_ZERO_PAGE, bal_sum[7:0]};
            rw_nxt    = 1'b0;
            wdata_nxt = store_data_in;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = pc2;
            pc_nxt   = pc2;
          end
        end
        CBS_INDY_ST: begin
          if (t_r == 3'd1) begin
            ptr_nxt  = data_in;
            addr_nxt = {`CBS_ZERO_PAGE, data_in};
          end else if (t_r == 3'd2) begin
            lo_nxt   = data_in;
            addr_nxt = {`CBS_ZERO_PAGE, pointer_low_byte_r + 8'h01};
          end else if (t_r == 3'd3) begin
            hi_nxt   = data_in;
            addr_nxt = {data_in, effective_low_byte_r + index_y_in};
          end else if (t_r == 3'd4) begin
            hi_nxt    = effective_high_byte_r + {7'd0, bal_sum[8]};
            addr_nxt  = {effective_high_byte_r + {7'd0, bal_sum[8]}, bal_sum[7:0]};
            rw_nxt    = 1'b0;
            wdata_nxt = store_data_in;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = pc2;
            pc_nxt   = pc2;
          end
        end
        CBS_RMW_ZP, CBS_RMW_ABS, CBS_RMW_ZPX, CBS_RMW_ABSX: begin
          if (t_r == 3'd1) begin
            if (cls_r == CBS_RMW_ZP || cls_r == CBS_RMW_ZPX) begin
              hi_nxt   = `CBS_ZERO_PAGE;
              addr_nxt = {`CBS_ZERO_PAGE, data_in};
            end else begin
              addr_nxt = pc2;
            end
          end else if (t_r == 3'd2 && cls_r == CBS_RMW_ZPX) begin
            lo_nxt   = bal_sum[7:0];
            addr_nxt = {`CBS_ZERO_PAGE, bal_sum[7:0]};
          end else if (t_r == 3'd2 && cls_r == CBS_RMW_ABS) begin
            hi_nxt   = data_in;
            addr_nxt = {data_in, effective_low_byte_r};
          end else if (t_r == 3'd2 && cls_r == CBS_RMW_ABSX) begin
            lo_nxt   = bal_sum[7:0];
            hi_nxt   = data_in + {7'd0, bal_sum[8]};
            addr_nxt = {data_in + {7'd0, bal_sum[8]}, bal_sum[7:0]};
          end else if (t_r == 3'd3 && cls_r == CBS_RMW_ABSX) begin
            addr_nxt = addr_r;
          end else if (!rw_r && ((cls_r == CBS_RMW_ZP && t_r == 3'd3)
                       || (cls_r == CBS_RMW_ABSX && t_r == 3'd5)
                       || (cls_r != CBS_RMW_ZP && t_r == 3'd4))) begin
            rw_nxt    = 1'b0;
            wdata_nxt = modify_data_in;
          end else if (rw_r) begin
            opnd_nxt  = data_in;
            opv_nxt   = 1'b1;
            rw_nxt    = 1'b0;
            wdata_nxt = data_in;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = (cls_r == CBS_RMW_ABS || cls_r == CBS_RMW_ABSX) ? pc3 : pc2;
            pc_nxt   = (cls_r == CBS_RMW_ABS || cls_r == CBS_RMW_ABSX) ? pc3 : pc2;
          end
        end
        CBS_PUSH: begin
          if (t_r == 3'd1) begin
            addr_nxt  = stk;
            rw_nxt    = 1'b0;
            wdata_nxt = store_data_in;
            sp_nxt    = sp_r - 8'h01;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = pc1;
            pc_nxt   = pc1;
          end
        end
        CBS_PULL: begin
          if (t_r == 3'd1) begin
            addr_nxt = stk;
          end else if (t_r == 3'd2) begin
            addr_nxt = stk_up;
            sp_nxt   = sp_r + 8'h01;
          end else begin
            opnd_nxt = data_in;
            opv_nxt  = 1'b1;
            t_nxt    = 3'd0;
            addr_nxt = pc1;
            pc_nxt   = pc1;
          end
        end
        CBS_CALL: begin
          if (t_r == 3'd1) begin
            addr_nxt = stk;
          end else if (t_r == 3'd2) begin
            rw_nxt    = 1'b0;
            wdata_nxt = pc2[15:8];
            sp_nxt    = sp_r - 8'h01;
          end else if (t_r == 3'd3) begin
            addr_nxt  = stk;
            rw_nxt    = 1'b0;
            wdata_nxt = pc2[7:0];
            sp_nxt    = sp_r - 8'h01;
          end else if (t_r == 3'd4) begin
            addr_nxt = pc2;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = {data_in, effective_low_byte_r};
            pc_nxt   = {data_in, effective_low_byte_r};
          end
        end
        CBS_BREAK, CBS_INT, CBS_RESET: begin
          if (t_r == 3'd1 || t_r == 3'd2 || t_r == 3'd3) begin
            addr_nxt  = stk;
            rw_nxt    = 1'b0;
            sp_nxt    = sp_r - 8'h01;
            wdata_nxt = (t_r == 3'd1) ? ret_addr[15:8] :
                        (t_r == 3'd2) ? ret_addr[7:0] : status_in;
          end else if (t_r == 3'd4) begin
            addr_nxt = vec_r;
          end else if (t_r == `CBS_ENTRY_VEC_LO) begin
            lo_nxt   = data_in;
            addr_nxt = vec_r | 16'h0001;
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = {data_in, effective_low_byte_r};
            pc_nxt   = {data_in, effective_low_byte_r};
          end
        end
        CBS_RTI, CBS_RTS: begin
          if (t_r == 3'd1) begin
            addr_nxt = stk;
          end else if (t_r == 3'd2 || (t_r == 3'd3 && cls_r == CBS_RTS)
                       || (t_r == 3'd3 || t_r == 3'd4) && cls_r == CBS_RTI) begin
            if (t_r == 3'd3 && cls_r == CBS_RTI) begin
              opnd_nxt = data_in;
              opv_nxt  = 1'b1;
            end else if (t_r != 3'd2) begin
              lo_nxt   = data_in;
            end
            addr_nxt = stk_up;
            sp_nxt   = sp_r + 8'h01;
          end else if (cls_r == CBS_RTS && t_r == 3'd4) begin
            hi_nxt   = data_in;
            addr_nxt = {data_in, effective_low_byte_r};
          end else begin
            t_nxt = 3'd0;
            if (cls_r == CBS_RTI) begin
              addr_nxt = {data_in, effective_low_byte_r};
              pc_nxt   = {data_in, effective_low_byte_r};
            end else begin
              addr_nxt = addr_r + 16'h0001;
              pc_nxt   = addr_r + 16'h0001;
            end
          end
        end
        CBS_JMP_ABS, CBS_JMP_IND: begin
          if (t_r == 3'd1) begin
            addr_nxt = pc2;
          end else if (t_r == 3'd2 && cls_r == CBS_JMP_IND) begin
            ptr_nxt  = effective_low_byte_r;
            hi_nxt   = data_in;
            addr_nxt = {data_in, effective_low_byte_r};
          end else if (t_r == 3'd3) begin
            lo_nxt   = data_in;
            addr_nxt = {effective_high_byte_r, pointer_low_byte_r + 8'h01};
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = {data_in, effective_low_byte_r};
            pc_nxt   = {data_in, effective_low_byte_r};
          end
        end
        CBS_BRANCH: begin
          if (t_r == 3'd1 && !branch_taken_in) begin
            t_nxt    = 3'd0;
            addr_nxt = pc2;
            pc_nxt   = pc2;
          end else if (t_r == 3'd1) begin
            hi_nxt   = br_tgt[15:8];
            lo_nxt   = br_tgt[7:0];
            addr_nxt = {pc2[15:8], br_tgt[7:0]};
          end else if (t_r == 3'd2 && effective_high_byte_r != pc2[15:8]) begin
            addr_nxt = {effective_high_byte_r, effective_low_byte_r};
          end else begin
            t_nxt    = 3'd0;
            addr_nxt = {effective_high_byte_r, effective_low_byte_r};
            pc_nxt   = {effective_high_byte_r, effective_low_byte_r};
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // sequence and bus registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cls_r   <= CBS_RESET;
      t_r     <= `CBS_ENTRY_VEC_LO;
      addr_r  <= `CBS_VEC_RESET;
      rw_r    <= 1'b1;
      wdata_r <= 8'h00;
      sync_r  <= 1'b0;
      oe_r    <= 1'b0;
      vec_r   <= `CBS_VEC_RESET;
    end else if (advance) begin
      cls_r   <= cls_nxt;
      t_r     <= t_nxt;
      addr_r  <= addr_nxt;
      rw_r    <= rw_nxt;
      wdata_r <= wdata_nxt;
      sync_r  <= (t_nxt == 3'd0);
      oe_r    <= ~rw_nxt;
      vec_r   <= vec_nxt;
    end
  end

  // ****************************************************************
  // address and stack registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pc_r                  <= 16'h0000;
      sp_r                  <= `CBS_SP_RESET;
      effective_low_byte_r  <= 8'h00;
      effective_high_byte_r <= 8'h00;
      pointer_low_byte_r    <= 8'h00;
    end else if (advance) begin
      pc_r                  <= pc_nxt;
      sp_r                  <= sp_nxt;
      effective_low_byte_r  <= lo_nxt;
      effective_high_byte_r <= hi_nxt;
      pointer_low_byte_r    <= ptr_nxt;
    end
  end

  // ****************************************************************
  // operand capture
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    opnd_r <= reset_in ? 8'h00 : (advance ? opnd_nxt : opnd_r);
    opv_r  <= ~reset_in & advance & opv_nxt;
  end

  assign addr_out              = addr_r;
  assign data_out              = wdata_r;
  assign data_oe_out           = oe_r;
  assign rw_out                = rw_r;
  assign sync_out              = sync_r;
  assign cycle_state_index_out = t_r;
  assign operand_out           = opnd_r;
  assign operand_valid_out     = opv_r;

endmodule : cbs_sequencer
`default_nettype wire

// >>> cbs_sequencer_props.sv
`default_nettype none
module cbs_sequencer_props
  import cbs_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  // control inputs
  input wire logic        ready_in,
  input wire logic [7:0]  modify_data_in,
  // memory bus
  input wire logic [15:0] addr_out,
  input wire logic [7:0]  data_out,
  input wire logic        rw_out,
  input wire logic        sync_out,
  input wire logic [2:0]  cycle_state_index_out,
  input wire logic        operand_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // bus sequence checks
  // ****************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_sync_read: assert property (
    sync_out |-> rw_out && cycle_state_index_out == 3'd0)
    else $error("opcode fetch is not a state zero read");
  chk_write_moves_on: assert property (
    !rw_out |=> cycle_state_index_out != $past(cycle_state_index_out))
    else $error("write cycle was held");
  chk_read_hold: assert property (
    rw_out && !ready_in |=> rw_out && $stable(addr_out) && $stable(cycle_state_index_out))
    else $error("read cycle not held while ready is low");
  chk_rmw_same_addr: assert property (
    !rw_out && !$past(rw_out) && addr_out[15:8] != 8'h01
    |-> $stable(addr_out) && $past(rw_out, 2) && $past(addr_out, 2) == addr_out)
    else $error("modify writes not at the operand address");
  chk_rmw_new_value: assert property (
    !rw_out && !$past(rw_out) && addr_out[15:8] != 8'h01 |-> data_out == $past(modify_data_in))
    else $error("second modify write lacks the modified value");
  chk_push_page: assert property (
    !rw_out && cycle_state_index_out == 3'd2 |-> addr_out[15:8] == 8'h01)
    else $error("early write is off the stack page");
  chk_push_order: assert property (
    !rw_out && !$past(rw_out) && addr_out[15:8] == 8'h01
    |-> addr_out == $past(addr_out) - 16'h0001)
    else $error("stack pushes do not descend");
  chk_vector_pair: assert property (
    rw_out && ready_in && addr_out inside {16'hFFFA, 16'hFFFC, 16'hFFFE}
    |=> (addr_out == $past(addr_out) + 16'h0001) ##1 sync_out)
    else $error("vector high byte or opcode fetch missing");
  chk_operand_read: assert property (
    operand_valid_out |-> $past(rw_out))
    else $error("operand captured without a read");

  cov_rmw: cover property (!rw_out ##1 !rw_out && addr_out[15:8] == 8'h00);
  cov_hold: cover property (rw_out && !ready_in ##1 !ready_in);
  cov_nmi: cover property (rw_out && addr_out == 16'hFFFA);
endmodule : cbs_sequencer_props

bind cbs_sequencer cbs_sequencer_props cbs_sequencer_props_inst (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .ready_in(ready_in),
  .modify_data_in(modify_data_in), .addr_out(addr_out), .data_out(data_out),
  .rw_out(rw_out), .sync_out(sync_out), .cycle_state_index_out(cycle_state_index_out),
  .operand_valid_out(operand_valid_out));
`default_nettype wire

// >>> cbs_sequencer_tb.sv
`default_nettype none
module cbs_sequencer_tb import cbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    cbs_class_t  c;
    logic [2:0]  f;
    int          n, k1;
    logic        w1;
    logic [23:0] e1;
    int          k2;
    logic        w2;
    logic [23:0] e2;
  } cbs_row_t;
  logic        sys_clk_in, reset_in, ready_in, taken, irq, nmi, rw, sync, oe, opv;
  cbs_class_t  op_class;
  logic [7:0]  rd, dout, oper;
  logic [15:0] addr, held;
  logic [2:0]  idx;
  logic [24:0] trace [16];
  int          n_cyc = 0;
  int          num_errors = 0;
  int          check_count = 0;
  localparam logic [23:0] PRE [23] = '{24'hFFFD_02, 24'h0201_FE, 24'h0203_F8, 24'h0205_40,
    24'h0040_F8, 24'h0041_12, 24'h0207_30, 24'h0030_5A, 24'h0209_34, 24'h020A_12, 24'h1234_11,
    24'h020C_FD, 24'h020E_FE, 24'h020F_12, 24'h0214_03, 24'h0217_04, 24'h0401_FF, 24'h0402_05,
    24'h0500_06, 24'hFFFF_07, 24'hFFFB_07, 24'h0605_10, 24'h0617_80};
  cbs_row_t rows [23] = '{
    '{CBS_ZPX_ST, 3'd0, 4, 2, 1, 24'h00FE_00, 3, 0, 24'h0003_77},
    '{CBS_ZPY_ST, 3'd0, 4, 2, 1, 24'h00F8_00, 3, 0, 24'h0008_77},
    '{CBS_INDY_ST, 3'd0, 6, 4, 1, 24'h1208_00, 5, 0, 24'h1308_77},
    '{CBS_RMW_ZP, 3'd0, 5, 3, 0, 24'h0030_5A, 4, 0, 24'h0030_A5},
    '{CBS_RMW_ABS, 3'd0, 6, 4, 0, 24'h1234_11, 5, 0, 24'h1234_A5},
    '{CBS_RMW_ZPX, 3'd0, 6, 2, 1, 24'h00FD_00, 5, 0, 24'h0002_A5},
    '{CBS_RMW_ABSX, 3'd0, 7, 4, 1, 24'h1303_00, 6, 0, 24'h1303_A5},
    '{CBS_PUSH, 3'd0, 3, 1, 1, 24'h0211_00, 2, 0, 24'h01FF_77},
    '{CBS_PULL, 3'd0, 4, 2, 1, 24'h01FE_00, 3, 1, 24'h01FF_77},
    '{CBS_CALL, 3'd0, 6, 4, 0, 24'h01FE_14, 5, 1, 24'h0214_03},
    '{CBS_RTS, 3'd0, 6, 3, 1, 24'h01FE_14, 5, 1, 24'h0214_03},
    '{CBS_JMP_ABS, 3'd0, 3, 1, 1, 24'h0216_00, 2, 1, 24'h0217_04},
    '{CBS_JMP_IND, 3'd0, 5, 3, 1, 24'h05FF_00, 4, 1, 24'h0500_06},
    '{CBS_BREAK, 3'd0, 7, 2, 0, 24'h01FF_06, 4, 0, 24'h01FD_3C},
    '{CBS_RTI, 3'd0, 6, 3, 1, 24'h01FD_3C, 5, 1, 24'h01FF_06},
    '{CBS_INT, 3'd1, 7, 1, 1, 24'h0602_00, 3, 0, 24'h01FE_02},
    '{CBS_RTI, 3'd0, 6, 3, 1, 24'h01FD_3C, 5, 1, 24'h01FF_06},
    '{CBS_INT, 3'd2, 7, 5, 1, 24'hFFFA_00, 6, 1, 24'hFFFB_07},
    '{CBS_RTI, 3'd0, 6, 3, 1, 24'h01FD_3C, 5, 1, 24'h01FF_06},
    '{CBS_BRANCH, 3'd0, 2, 1, 1, 24'h0603_00, 1, 1, 24'h0603_00},
    '{CBS_BRANCH, 3'd4, 3, 1, 1, 24'h0605_10, 2, 1, 24'h0616_00},
    '{CBS_BRANCH, 3'd4, 4, 2, 1, 24'h0698_00, 3, 1, 24'h0598_00},
    '{CBS_OTHER, 3'd0, 2, 1, 1, 24'h0599_00, 0, 1, 24'h0598_00}};

  cbs_sequencer cbs_sequencer_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .ready_in(ready_in), .op_class_in(op_class), .index_x_in(8'h05), .index_y_in(8'h10),
    .store_data_in(8'h77), .status_in(8'h3C), .modify_data_in(8'hA5), .branch_taken_in(taken),
    .irq_req_in(irq), .nmi_req_in(nmi), .data_in(rd), .addr_out(addr), .data_out(dout),
    .data_oe_out(oe), .rw_out(rw), .sync_out(sync), .cycle_state_index_out(idx),
    .operand_out(oper), .operand_valid_out(opv));
  cbs_memory_model cbs_memory_model_inst (.sys_clk_in(sys_clk_in), .addr_in(addr),
    .rw_in(rw), .data_in(dout), .data_out(rd));

  // ****************
  // clock, trace and tasks
  // ****************
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // one entry per completed bus cycle
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      n_cyc = 0;
    end else if (ready_in || !rw) begin
      if (sync) n_cyc = 0;
      trace[n_cyc % 16] = {rw, addr, rw ? rd : dout};
      n_cyc++;
    end
  end

  task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_sync;
    for (int i = 0; i < 12 && sync !== 1'b1; i++) @(posedge sys_clk_in) #1;
  endtask : wait_sync

  task automatic do_reset;
    reset_in = 1'b1;
    repeat (16) @(posedge sys_clk_in);
    #1 reset_in = 1'b0;
    wait_sync();
    check("reset cycles", 25'd2, 25'(n_cyc));
    check("vector high", {1'b1, 24'hFFFD_02}, trace[1]);
    check("start address", {9'h000, 16'h0200}, {9'h000, addr});
    $display("reset test done");
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3000) @(posedge sys_clk_in);
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    {reset_in, ready_in, taken, irq, nmi} = 5'b11000;
    op_class = CBS_OTHER;
    foreach (PRE[i]) cbs_memory_model_inst.mem[PRE[i][23:8]] = PRE[i][7:0];
    do_reset();
    foreach (rows[j]) begin
      op_class = rows[j].c;
      {taken, nmi, irq} = rows[j].f;
      @(posedge sys_clk_in) #1;
      {nmi, irq} = 2'b00;
      wait_sync();
      check("cycle count", 25'(rows[j].n), 25'(n_cyc));
      check("first key cycle", {rows[j].w1, rows[j].e1}, trace[rows[j].k1]);
      check("second key cycle", {rows[j].w2, rows[j].e2}, trace[rows[j].k2]);
      if (rows[j].c == CBS_PULL) check("pulled", {17'h0_0000, 8'h77}, {17'h0_0000, oper});
      $display("row %0d done", j);
    end
    // ready low while the push write is on the bus
    op_class = CBS_PUSH;
    taken = 1'b0;
    repeat (2) @(posedge sys_clk_in) #1;
    check("write cycle", 25'd0, {24'h00_0000, rw});
    check("drive enable", 25'd1, {24'h00_0000, oe});
    ready_in = 1'b0;
    @(posedge sys_clk_in) #1;
    held = addr;
    check("drive released", 25'd0, {24'h00_0000, oe});
    check("write not held", 25'd1, {24'h00_0000, sync});
    repeat (3) @(posedge sys_clk_in) #1;
    check("read held", {9'h000, held}, {9'h000, addr});
    check("pushed", {17'h0_0000, 8'h77}, {17'h0_0000, cbs_memory_model_inst.mem[16'h01FF]});
    ready_in = 1'b1;
    $display("stepping test done");
    @(posedge sys_clk_in) #1;
    do_reset();
    wrap_up();
  end
endmodule : cbs_sequencer_tb
`default_nettype wire
